/* File: shared/dcc_pkg.sv */
// Package: register map, field layout and carrier types for the reference/comparator control
package dcc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NUM_CMP = 2;
    localparam int unsigned LEVEL_W = 5;
    localparam int unsigned CYC_PER_INSTR = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] VREF0_OFS = 8'h00;
    localparam logic [7:0] VREF1_OFS = 8'h04;
    localparam logic [7:0] CMP_CON0_OFS = 8'h08;
    localparam logic [7:0] CMP_CON1_OFS = 8'h0C;
    localparam logic [7:0] CMP_STRIDE = 8'h08;
    localparam logic [7:0] CMP_OUT_OFS = 8'h18;
    localparam logic [7:0] PIN_CTL_OFS = 8'h1C;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int unsigned VREF_EN_BIT = 7;
    localparam int unsigned VREF_OE1_BIT = 5;
    localparam int unsigned VREF_OE2_BIT = 4;
    localparam int unsigned VREF_PSS_LSB = 2;
    localparam int unsigned CMP_ON_BIT = 7;
    localparam int unsigned CMP_RES_BIT = 6;
    localparam int unsigned CMP_OE_BIT = 5;
    localparam int unsigned CMP_POL_BIT = 4;
    localparam int unsigned CMP_SP_BIT = 2;
    localparam int unsigned CMP_HYS_BIT = 1;
    localparam int unsigned CMP_SYNC_BIT = 0;
    localparam logic [7:0] CMP_CON1_MASK = 8'hF7;
    localparam int unsigned PIN_PIN_TRISTATE_CONTROL_LSB = 0;
    localparam int unsigned PIN_LATCH_LSB = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CMP_CON0_RST = 8'h04;
    localparam logic [7:0] CMP_CON1_RST = 8'h00;
    localparam logic [NUM_CMP-1:0] PIN_PIN_TRISTATE_CONTROL_RST = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DCC_PSS_SUPPLY = 2'h0,
        DCC_PSS_EXTREF = 2'h1,
        DCC_PSS_FIXED = 2'h2,
        DCC_PSS_RSVD = 2'h3
    } dcc_pss_t;

    typedef struct packed
    {
        logic en;
        logic oe1;
        logic oe2;
        dcc_pss_t pss;
    } dcc_vref_ctrl_t;

    typedef struct packed
    {
        logic on;
        logic oe;
        logic pol;
        logic sp;
        logic hys;
        logic sync;
    } dcc_cmp_ctrl_t;

endpackage : dcc_pkg

/* File: core/dcc_sync.sv */
// Two-flop synchroniser for asynchronous single-bit inputs
`timescale 1ns/100ps
module dcc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : dcc_sync

/* File: core/dcc_ctrl_top.sv */
// Reference ladder and dual comparator control with APB register access
//
// Functional notes
// - Enable bit switches reference generator on
// - Two bits connect reference to pins
// - Reference pin: digital off, reads zero
// - Two-bit field selects ladder top source
// - Five-bit level field selects ladder tap
// - Sleep wake leaves reference control unchanged
// - Reset disables reference, pins, clears level
// - Unimplemented bits read as zero
// - Comparator works only while on bit set
// - Result readable in control and mirror
// - Pin driven needs enable, tristate clear, on
// - Output enable overrides latch, pin released while output enable set and on clear
// - Internal result latched each instruction cycle
// - Polarity bit inverts comparator result
// - Speed bit resets to normal speed
// - Hysteresis bit applies input hysteresis
// - Result offered as timer gate source
// - Two comparators, two control registers each
// - First control register bit layout
// - Sync latches result on timer falling edge
`timescale 1ns/100ps
module dcc_ctrl_top
    import dcc_pkg::*;
#(
    parameter int unsigned INSTR_CYC = CYC_PER_INSTR
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Analogue reference controls
    output dcc_vref_ctrl_t vref_ctrl_out,
    output logic [LEVEL_W-1:0] vref_level_out,
    // Reference pins, digital side
    input wire logic [1:0] vref_pin_in,
    output logic [1:0] vref_pin_read_out,
    // Comparator analogue side
    input wire logic [NUM_CMP-1:0] cmp_raw_in,
    output dcc_cmp_ctrl_t [NUM_CMP-1:0] cmp_ctrl_out,
    output logic [NUM_CMP-1:0][7:0] cmp_sel_out,
    // Comparator pins
    output logic [NUM_CMP-1:0] cmp_pin_out,
    output logic [NUM_CMP-1:0] cmp_pin_oe_b_out,
    // Timer link
    input wire logic t1_clk_in,
    output logic [NUM_CMP-1:0] t1_gate_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] dcc_pack_con0(dcc_cmp_ctrl_t c, logic res);
        logic [7:0] b;
        b = 8'h00;
        b[CMP_ON_BIT] = c.on;
        b[CMP_RES_BIT] = res;
        b[CMP_OE_BIT] = c.oe;
        b[CMP_POL_BIT] = c.pol;
        b[CMP_SP_BIT] = c.sp;
        b[CMP_HYS_BIT] = c.hys;
        b[CMP_SYNC_BIT] = c.sync;
        return b;
    endfunction : dcc_pack_con0

    function automatic dcc_cmp_ctrl_t dcc_unpack_con0(logic [7:0] b);
        dcc_cmp_ctrl_t c;
        c.on = b[CMP_ON_BIT];
        c.oe = b[CMP_OE_BIT];
        c.pol = b[CMP_POL_BIT];
        c.sp = b[CMP_SP_BIT];
        c.hys = b[CMP_HYS_BIT];
        c.sync = b[CMP_SYNC_BIT];
        return c;
    endfunction : dcc_unpack_con0

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [NUM_CMP-1:0] cmp_raw_s;
    logic [1:0] vref_pin_s;
    logic t1_clk_s;

    dcc_sync #(
        .WIDTH(NUM_CMP + 3)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .async_in({t1_clk_in, vref_pin_in, cmp_raw_in}),
        .sync_out({t1_clk_s, vref_pin_s, cmp_raw_s})
    );

    // ------------------------------------------------------------
    // Instruction cycle enable and timer edge
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = $clog2(INSTR_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INSTR_CYC - 1);

    logic [CNT_W-1:0] instr_cnt_q;
    logic instr_en_q;
    logic t1_prev_q;
    wire instr_wrap_w = (instr_cnt_q == CNT_LAST);
    wire t1_fall_w = t1_prev_q & ~t1_clk_s;

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            instr_cnt_q <= '0;
            instr_en_q <= 1'b0;
            t1_prev_q <= 1'b0;
        end
        else
        begin
            instr_cnt_q <= instr_wrap_w ? '0 : instr_cnt_q + 1'b1;
            instr_en_q <= instr_wrap_w;
            t1_prev_q <= t1_clk_s;
        end
    end

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DCC_APB_IDLE = 2'b01,
        DCC_APB_DONE = 2'b10
    } dcc_apb_st_t;

    dcc_apb_st_t apb_st_q;
    dcc_apb_st_t apb_st_d;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    wire setup_w = psel_in & ~penable_in & (apb_st_q == DCC_APB_IDLE);
    wire wr_en_w = psel_in & penable_in & pready_q & pwrite_in;

    always_comb
    begin
        case (apb_st_q)
            DCC_APB_IDLE: apb_st_d = setup_w ? DCC_APB_DONE : DCC_APB_IDLE;
            DCC_APB_DONE: apb_st_d = DCC_APB_IDLE;
            default: apb_st_d = DCC_APB_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Reference registers
    // ------------------------------------------------------------
    dcc_vref_ctrl_t vref_q;
    logic [LEVEL_W-1:0] level_q;
    logic [NUM_CMP-1:0] pin_tristate_control_q;
    logic [NUM_CMP-1:0] latch_q;
    logic [1:0] pin_read_q;

    wire hit_v0_w = (paddr_in == VREF0_OFS);
    wire hit_v1_w = (paddr_in == VREF1_OFS);
    wire hit_out_w = (paddr_in == CMP_OUT_OFS);
    wire hit_pin_w = (paddr_in == PIN_CTL_OFS);
    wire [1:0] vref_oe_w = {vref_q.oe2, vref_q.oe1};

    // Only reset or a bus write changes these, so a wake from sleep keeps them
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            vref_q <= '0;
            level_q <= '0;
            pin_tristate_control_q <= PIN_PIN_TRISTATE_CONTROL_RST;
            latch_q <= '0;
        end
        else
        begin
            if (wr_en_w && hit_v0_w)
            begin
                vref_q.en <= pwdata_in[VREF_EN_BIT];
                vref_q.oe1 <= pwdata_in[VREF_OE1_BIT];
                vref_q.oe2 <= pwdata_in[VREF_OE2_BIT];
                vref_q.pss <= dcc_pss_t'(pwdata_in[VREF_PSS_LSB +: 2]);
            end
            if (wr_en_w && hit_v1_w)
            begin
                level_q <= pwdata_in[LEVEL_W-1:0];
            end
            if (wr_en_w && hit_pin_w)
            begin
                pin_tristate_control_q <= pwdata_in[PIN_PIN_TRISTATE_CONTROL_LSB +: NUM_CMP];
                latch_q <= pwdata_in[PIN_LATCH_LSB +: NUM_CMP];
            end
        end
    end

    // Pin input is blanked while the pin carries the analogue level
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            pin_read_q <= '0;
        end
        else
        begin
            pin_read_q <= vref_pin_s & ~vref_oe_w;
        end
    end

    // Unimplemented positions stay zero in the read image
    wire [7:0] vref0_rd_w = {vref_q.en, 1'b0, vref_q.oe1, vref_q.oe2, vref_q.pss, 2'b00};
    wire [7:0] vref1_rd_w = {{(8 - LEVEL_W){1'b0}}, level_q};
    wire [7:0] pin_rd_w = {{(8 - PIN_LATCH_LSB - NUM_CMP){1'b0}}, latch_q,
                           {(PIN_LATCH_LSB - NUM_CMP){1'b0}}, pin_tristate_control_q};

    // ------------------------------------------------------------
    // Comparator channels
    // ------------------------------------------------------------
    dcc_cmp_ctrl_t [NUM_CMP-1:0] cmp_q;
    logic [NUM_CMP-1:0][7:0] con1_q;
    logic [NUM_CMP-1:0] result_q;
    logic [NUM_CMP-1:0] sync_res_q;
    logic [NUM_CMP-1:0] gate_q;
    logic [NUM_CMP-1:0] pin_q;
    logic [NUM_CMP-1:0] pin_oe_b_q;
    logic [NUM_CMP-1:0] pol_w;
    logic [NUM_CMP-1:0] ext_w;
    logic [NUM_CMP-1:0] hit_c0_w;
    logic [NUM_CMP-1:0] hit_c1_w;
    logic [NUM_CMP-1:0][7:0] cmp_rd_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_cmp
            localparam logic [7:0] OFS0 = CMP_CON0_OFS + 8'(gi) * CMP_STRIDE;
            localparam logic [7:0] OFS1 = CMP_CON1_OFS + 8'(gi) * CMP_STRIDE;

            assign hit_c0_w[gi] = (paddr_in == OFS0);
            assign hit_c1_w[gi] = (paddr_in == OFS1);
            // Off comparator gives a low decision before polarity
            assign pol_w[gi] = (cmp_raw_s[gi] & cmp_q[gi].on) ^ cmp_q[gi].pol;
            assign ext_w[gi] = cmp_q[gi].sync ? sync_res_q[gi] : pol_w[gi];
            assign cmp_rd_w[gi] = ({8{hit_c0_w[gi]}} & dcc_pack_con0(cmp_q[gi], result_q[gi]))
                                | ({8{hit_c1_w[gi]}} & con1_q[gi] & CMP_CON1_MASK);

            always_ff @(posedge core_clk_in)
            begin
                if (!rst_b_in)
                begin
                    cmp_q[gi] <= dcc_unpack_con0(CMP_CON0_RST);
                    con1_q[gi] <= CMP_CON1_RST;
                end
                else
                begin
                    if (wr_en_w && hit_c0_w[gi])
                    begin
                        cmp_q[gi] <= dcc_unpack_con0(pwdata_in[7:0]);
                    end
                    if (wr_en_w && hit_c1_w[gi])
                    begin
                        con1_q[gi] <= pwdata_in[7:0] & CMP_CON1_MASK;
                    end
                end
            end

            always_ff @(posedge core_clk_in)
            begin
                if (!rst_b_in)
                begin
                    result_q[gi] <= 1'b0;
                    sync_res_q[gi] <= 1'b0;
                    gate_q[gi] <= 1'b0;
                    pin_q[gi] <= 1'b0;
                    pin_oe_b_q[gi] <= 1'b1;
                end
                else
                begin
                    if (instr_en_q)
                    begin
                        result_q[gi] <= pol_w[gi];
                    end
                    if (t1_fall_w)
                    begin
                        sync_res_q[gi] <= pol_w[gi];
                    end
                    gate_q[gi] <= ext_w[gi];
                    pin_q[gi] <= cmp_q[gi].oe ? ext_w[gi] : latch_q[gi];
                    pin_oe_b_q[gi] <= pin_tristate_control_q[gi] | (cmp_q[gi].oe & ~cmp_q[gi].on);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire mapped_w = hit_v0_w | hit_v1_w | hit_out_w | hit_pin_w | (|hit_c0_w) | (|hit_c1_w);
    wire [7:0] out_rd_w = {{(8 - NUM_CMP){1'b0}}, result_q};
    wire [7:0] rd_w = ({8{hit_v0_w}} & vref0_rd_w) | ({8{hit_v1_w}} & vref1_rd_w)
                    | ({8{hit_out_w}} & out_rd_w) | ({8{hit_pin_w}} & pin_rd_w)
                    | cmp_rd_w[0] | cmp_rd_w[1];

    // Answer in the first cycle of the access phase, data latched at setup
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            apb_st_q <= DCC_APB_IDLE;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            apb_st_q <= apb_st_d;
            pready_q <= setup_w;
            if (setup_w)
            begin
                prdata_q <= {24'h000000, rd_w};
                pslverr_q <= ~mapped_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign vref_ctrl_out = vref_q;
    assign vref_level_out = level_q;
    assign vref_pin_read_out = pin_read_q;
    assign cmp_ctrl_out = cmp_q;
    assign cmp_sel_out = con1_q;
    assign cmp_pin_out = pin_q;
    assign cmp_pin_oe_b_out = pin_oe_b_q;
    assign t1_gate_out = gate_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_apb_wr(logic [7:0] ofs);
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == ofs;
    endsequence

    sequence s_apb_setup(logic [7:0] ofs);
        psel_in && !penable_in && !pready_out && paddr_in == ofs;
    endsequence

    property p_vref_rst;
        disable iff (1'b0) !rst_b_in |=> vref_ctrl_out == '0 && vref_level_out == '0;
    endproperty
    a_vref_rst: assert property (p_vref_rst) else $error("reference not cleared by reset");

    property p_sp_rst;
        disable iff (1'b0) !rst_b_in |=> cmp_ctrl_out[0].sp && cmp_ctrl_out[1].sp;
    endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("speed bit not set by reset");

    property p_vref_en;
        s_apb_wr(VREF0_OFS) |=> vref_ctrl_out.en == $past(pwdata_in[VREF_EN_BIT]);
    endproperty
    a_vref_en: assert property (p_vref_en) else $error("enable write lost");

    property p_level_wr;
        s_apb_wr(VREF1_OFS) |=> vref_level_out == $past(pwdata_in[LEVEL_W-1:0]);
    endproperty
    a_level_wr: assert property (p_level_wr) else $error("level write lost");

    property p_vref0_rsvd;
        s_apb_setup(VREF0_OFS) |=> pready_out && prdata_out[6] == 1'b0 && prdata_out[1:0] == 2'h0;
    endproperty
    a_vref0_rsvd: assert property (p_vref0_rsvd) else $error("reserved bits read nonzero");

    property p_pin_read_zero;
        vref_ctrl_out.oe1 |=> !vref_pin_read_out[0];
    endproperty
    a_pin_read_zero: assert property (p_pin_read_zero) else $error("reference pin read not zero");

    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_chk
            property p_pol;
                instr_en_q && cmp_ctrl_out[gi].on |=>
                    result_q[gi] == $past(cmp_raw_s[gi] ^ cmp_ctrl_out[gi].pol);
            endproperty
            a_pol: assert property (p_pol) else $error("polarity result wrong");

            property p_off_zero;
                instr_en_q && !cmp_ctrl_out[gi].on && !cmp_ctrl_out[gi].pol |=> !result_q[gi];
            endproperty
            a_off_zero: assert property (p_off_zero) else $error("off comparator not low");

            property p_hold;
                !instr_en_q |=> $stable(result_q[gi]);
            endproperty
            a_hold: assert property (p_hold) else $error("result moved between cycles");

            property p_drive;
                cmp_ctrl_out[gi].oe && cmp_ctrl_out[gi].on && !pin_tristate_control_q[gi] |=> !cmp_pin_oe_b_out[gi];
            endproperty
            a_drive: assert property (p_drive) else $error("pin not driven");

            property p_off_nodrive;
                cmp_ctrl_out[gi].oe && !cmp_ctrl_out[gi].on |=> cmp_pin_oe_b_out[gi];
            endproperty
            a_off_nodrive: assert property (p_off_nodrive) else $error("off comparator drives");

            property p_override;
                cmp_ctrl_out[gi].oe && !cmp_ctrl_out[gi].sync |=> cmp_pin_out[gi] == $past(pol_w[gi]);
            endproperty
            a_override: assert property (p_override) else $error("pin not overridden");

            sequence s_sync_quiet;
                (cmp_ctrl_out[gi].sync && !t1_fall_w) [*2];
            endsequence

            property p_sync_hold;
                s_sync_quiet |=> $stable(t1_gate_out[gi]);
            endproperty
            a_sync_hold: assert property (p_sync_hold) else $error("gate moved without edge");

            property p_gate;
                !cmp_ctrl_out[gi].sync |=> t1_gate_out[gi] == $past(pol_w[gi]);
            endproperty
            a_gate: assert property (p_gate) else $error("gate source wrong");

            property p_mirror;
                s_apb_setup(CMP_OUT_OFS) |=> prdata_out[gi] == $past(result_q[gi]);
            endproperty
            a_mirror: assert property (p_mirror) else $error("mirror bit wrong");
        end
    endgenerate

endmodule : dcc_ctrl_top

/* File: tb/tb.sv */
// Self-checking bench for the reference and comparator control block
`timescale 1ns/100ps
module tb;
    import dcc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk_in, rst_b_in, psel_in, penable_in, pwrite_in, t1_clk_in;
    logic [ADDR_W-1:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, err;
    dcc_vref_ctrl_t vref_ctrl_out;
    logic [LEVEL_W-1:0] vref_level_out;
    logic [1:0] vref_pin_in, vref_pin_read_out, cmp_raw_in, cmp_pin_out, cmp_pin_oe_b_out;
    logic [1:0] t1_gate_out, res;
    dcc_cmp_ctrl_t [NUM_CMP-1:0] cmp_ctrl_out;
    logic [NUM_CMP-1:0][7:0] cmp_sel_out;
    int n_fail, tests_run, cyc;
    int m [8];
    dcc_ctrl_top u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .vref_ctrl_out(vref_ctrl_out),
        .vref_level_out(vref_level_out), .vref_pin_in(vref_pin_in),
        .vref_pin_read_out(vref_pin_read_out), .cmp_raw_in(cmp_raw_in),
        .cmp_ctrl_out(cmp_ctrl_out), .cmp_sel_out(cmp_sel_out), .cmp_pin_out(cmp_pin_out),
        .cmp_pin_oe_b_out(cmp_pin_oe_b_out), .t1_clk_in(t1_clk_in), .t1_gate_out(t1_gate_out));
    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do @(posedge core_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    // Model stores only the implemented bits
    task automatic wr_reg(input int i, input logic [31:0] d);
        int mk [8] = '{32'hBC, 32'h1F, 32'hB7, CMP_CON1_MASK, 32'hB7, CMP_CON1_MASK, 0, 32'h33};
        apb(1'b1, 8'(i * 4), d);
        if (i != 6)
            m[i] = d & mk[i];
    endtask : wr_reg
    task automatic do_reset(input int n);
        rst_b_in <= 1'b0;
        repeat (n) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        m = '{0, 0, 32'h04, 0, 32'h04, 0, 0, 32'h03};
    endtask : do_reset
    task automatic check_all();
        logic [31:0] e;
        repeat (16) @(posedge core_clk_in);
        for (int k = 0; k < 2; k++)
            res[k] = (m[2 + 2 * k][7] & cmp_raw_in[k]) ^ m[2 + 2 * k][4];
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            e = (i == 6) ? {30'h0, res} : m[i];
            if (i == 2 || i == 4)
                e[6] = res[i / 2 - 1];
            chk("read", e, rd);
            chk("err", 0, err);
        end
        chk("vref", {m[0][7], m[0][5], m[0][4], m[0][3:2]}, vref_ctrl_out);
        chk("level", m[1], vref_level_out);
        chk("pin_rd", vref_pin_in & ~{m[0][4], m[0][5]}, vref_pin_read_out);
        for (int k = 0; k < 2; k++)
        begin
            e = m[2 + 2 * k];
            chk("ctrl", {e[7], e[5], e[4], e[2], e[1], e[0]}, cmp_ctrl_out[k]);
            chk("sel", m[3 + 2 * k], cmp_sel_out[k]);
            chk("gate", res[k], t1_gate_out[k]);
            chk("pin", e[5] ? res[k] : m[7][4 + k], cmp_pin_out[k]);
            chk("oe_b", m[7][k] | (e[5] & ~e[7]), cmp_pin_oe_b_out[k]);
        end
    endtask : check_all
    task automatic summarize();
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {psel_in, penable_in, pwrite_in, t1_clk_in, paddr_in, pwdata_in} = '0;
        {vref_pin_in, cmp_raw_in, n_fail, tests_run, cyc} = '0;
        rst_b_in = 1'b0;
        void'($urandom(32'h6e41));
        do_reset(5);
        check_all();
        repeat (24)
        begin
            cmp_raw_in <= 2'($urandom);
            vref_pin_in <= 2'($urandom);
            wr_reg($urandom % 8, $urandom & 32'hFFFFFFFE);
            check_all();
        end
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(0, 32'h80 | (p << 2));
            check_all();
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmap_err", 1, err);
        chk("unmap_rd", 0, rd);
        apb(1'b1, 8'h02, 32'hFF);
        chk("unalign_err", 1, err);
        wr_reg(1, 32'h1F);
        do_reset(2);
        check_all();
        // Sync mode: gate frozen until timer clock falls
        // Software turns on sync before gating the timer
        wr_reg(2, 32'h81);
        cmp_raw_in <= 2'b00;
        t1_clk_in <= 1'b1;
        repeat (16) @(posedge core_clk_in);
        t1_clk_in <= 1'b0;
        repeat (16) @(posedge core_clk_in);
        cmp_raw_in <= 2'b01;
        repeat (20) @(posedge core_clk_in);
        chk("sync_hold", 0, t1_gate_out[0]);
        t1_clk_in <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        t1_clk_in <= 1'b0;
        repeat (12) @(posedge core_clk_in);
        chk("sync_take", 1, t1_gate_out[0]);
        summarize();
    end
endmodule : tb
